// [rtl/bmmc_decode.sv]
`timescale 1ns/1ps
// combinational address decoder for code and data spaces
module bmmc_decode (
	// mapping
	input wire logic map_normal_i,
	// code fetch
	input wire logic [15:0] code_addr_i,
	output bmmc_pkg::bmmc_tgt_e code_tgt_o,
	output logic [15:0] code_off_o,
	// data access
	input wire logic [15:0] data_addr_i,
	output bmmc_pkg::bmmc_tgt_e data_tgt_o
);
	// code space: ROM mirror always at 8000, low window by mode
	always_comb begin
		code_tgt_o = bmmc_pkg::BMMC_TGT_NONE;
		code_off_o = 16'h0000;
		if (code_addr_i >= bmmc_pkg::ROM_MIRROR_LO && code_addr_i <= bmmc_pkg::ROM_MIRROR_HI) begin
			code_tgt_o = bmmc_pkg::BMMC_TGT_ROM;
			code_off_o = code_addr_i - bmmc_pkg::ROM_MIRROR_LO;
		end else if (!map_normal_i && code_addr_i <= bmmc_pkg::ROM_HI) begin
			code_tgt_o = bmmc_pkg::BMMC_TGT_ROM;
			code_off_o = code_addr_i;
		end else if (map_normal_i && code_addr_i <= bmmc_pkg::RAM_HI) begin
			code_tgt_o = bmmc_pkg::BMMC_TGT_RAM;
			code_off_o = code_addr_i;
		end
	end
	// data space: RAM only in boot mode, IO window always
	always_comb begin
		data_tgt_o = bmmc_pkg::BMMC_TGT_NONE;
		if (data_addr_i >= bmmc_pkg::IO_LO) begin
			data_tgt_o = bmmc_pkg::BMMC_TGT_IO;
		end else if (!map_normal_i && data_addr_i <= bmmc_pkg::RAM_HI) begin
			data_tgt_o = bmmc_pkg::BMMC_TGT_RAM;
		end
	end
endmodule // bmmc_decode

// [rtl/bmmc_pkg.sv]
package bmmc_pkg;
	// address map, 16-bit spaces
	localparam logic [15:0] ROM_LO = 16'h0000;
	localparam logic [15:0] ROM_HI = 16'h17FF;
	localparam logic [15:0] ROM_MIRROR_LO = 16'h8000;
	localparam logic [15:0] ROM_MIRROR_HI = 16'h97FF;
	localparam logic [15:0] RAM_LO = 16'h0000;
	localparam logic [15:0] RAM_HI = 16'h1FFF;
	localparam logic [15:0] IO_LO = 16'hFD80;
	localparam logic [15:0] IO_HI = 16'hFFFF;
	localparam logic [15:0] CFG_ADDR = 16'hFF90;
	localparam logic [15:0] USB_CONTROL_REG_ADDR = 16'hFFFC;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	// configuration register fields
	localparam int MAP_BIT = 0;
	localparam int REV_LSB = 1;
	localparam int REV_MSB = 4;
	localparam int IRQ_ROUTE_BIT = 6;
	localparam int CLK_SEL_BIT = 7;
	localparam int ATTACH_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] USB_CONTROL_REG_RESET = 8'h00;
	// where a decoded access lands
	typedef enum logic [2:0] {
		BMMC_TGT_NONE,
		BMMC_TGT_ROM,
		BMMC_TGT_RAM,
		BMMC_TGT_IO
	} bmmc_tgt_e;
	// register state carried as one struct
	typedef struct packed {
		logic map_release;
		logic irq_route;
		logic clk_sel;
		logic bus_attach;
		logic [7:0] rdata;
	} bmmc_state_s;
endpackage

// [rtl/bmmc_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - boot mode: ROM at 0000 and 8000
// - boot mode: RAM read/write in data space
// - normal mode: ROM only at 8000
// - normal mode: RAM is code at 0000
// - normal mode: code RAM never writable
// - FD80-FFFF always shared buffers and registers
// - reset clears map and attach bits
// - first fetch from 0000 in ROM
// - firmware sets map bit, runs from RAM
// - attach only after map switch; not enforced, the attach bit is writable in boot mode too
// - map bit bit0, set-only, reset clears
// - ROM variant ignores map bit
// - bits 4..1 read-only revision
// - bit7 selects 12 or 48 MHz
// - bit6 routes external interrupt one source
module bmmc_top #(
	parameter bit ROM_VARIANT = 1'b0,
	parameter logic [3:0] REVISION = 4'h1 // arbitrary value
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// register port in data space
	input wire logic [15:0] data_addr_i,
	input wire logic data_rd_i,
	input wire logic data_wr_i,
	input wire logic [7:0] data_wdata_i,
	output logic [7:0] reg_rdata_o,
	// decoded data access
	output bmmc_pkg::bmmc_tgt_e data_tgt_o,
	output logic ram_data_we_o,
	output logic ram_data_re_o,
	output logic io_sel_o,
	// code fetch
	input wire logic [15:0] code_addr_i,
	input wire logic code_wr_i,
	output bmmc_pkg::bmmc_tgt_e code_tgt_o,
	output logic [15:0] code_off_o,
	output logic rom_sel_o,
	output logic ram_code_sel_o,
	output logic ram_code_we_o,
	output logic [15:0] reset_vector_o,
	// mode and control
	output logic map_normal_o,
	output logic bus_attach_o,
	output logic clk_48m_sel_o,
	// interrupt routing
	input wire logic port3_bit3_i,
	input wire logic [7:0] port2_i,
	output logic external_interrupt_one_o
);
	bmmc_pkg::bmmc_state_s st;
	bmmc_pkg::bmmc_state_s next_st;
	logic map_eff;
	logic cfg_wr;
	logic ctl_wr;
	logic [7:0] cfg_view;

	// ROM variant keeps the boot map whatever software writes
	assign map_eff = ROM_VARIANT ? 1'b0 : st.map_release;
	assign map_normal_o = map_eff;
	assign bus_attach_o = st.bus_attach;
	assign clk_48m_sel_o = st.clk_sel;
	assign reg_rdata_o = st.rdata;
	assign reset_vector_o = bmmc_pkg::RESET_VECTOR;

	bmmc_decode u_decode (
		.map_normal_i(map_eff),
		.code_addr_i(code_addr_i),
		.code_tgt_o(code_tgt_o),
		.code_off_o(code_off_o),
		.data_addr_i(data_addr_i),
		.data_tgt_o(data_tgt_o)
	);

	// strobes toward the memories
	assign rom_sel_o = (code_tgt_o == bmmc_pkg::BMMC_TGT_ROM);
	assign ram_code_sel_o = (code_tgt_o == bmmc_pkg::BMMC_TGT_RAM);
	// write path to code RAM gated off; no error, no stall
	assign ram_code_we_o = 1'b0;
	assign ram_data_we_o = data_wr_i && (data_tgt_o == bmmc_pkg::BMMC_TGT_RAM);
	assign ram_data_re_o = data_rd_i && (data_tgt_o == bmmc_pkg::BMMC_TGT_RAM);
	assign io_sel_o = (data_tgt_o == bmmc_pkg::BMMC_TGT_IO);

	// external interrupt one source select
	assign external_interrupt_one_o = st.irq_route ? (|port2_i) : port3_bit3_i;

	assign cfg_wr = data_wr_i && (data_addr_i == bmmc_pkg::CFG_ADDR);
	assign ctl_wr = data_wr_i && (data_addr_i == bmmc_pkg::USB_CONTROL_REG_ADDR);

	// revision is a constant, never part of the reset state
	always_comb begin
		cfg_view = 8'h00;
		cfg_view[bmmc_pkg::MAP_BIT] = st.map_release;
		cfg_view[bmmc_pkg::REV_MSB:bmmc_pkg::REV_LSB] = REVISION;
		cfg_view[bmmc_pkg::IRQ_ROUTE_BIT] = st.irq_route;
		cfg_view[bmmc_pkg::CLK_SEL_BIT] = st.clk_sel;
	end

	// next state: map bit is set-only, software can never clear it
	always_comb begin
		next_st = st;
		if (cfg_wr) begin
			next_st.map_release = st.map_release | data_wdata_i[bmmc_pkg::MAP_BIT];
			next_st.irq_route = data_wdata_i[bmmc_pkg::IRQ_ROUTE_BIT];
			next_st.clk_sel = data_wdata_i[bmmc_pkg::CLK_SEL_BIT];
		end
		if (ctl_wr) begin
			next_st.bus_attach = data_wdata_i[bmmc_pkg::ATTACH_BIT];
		end
		// read data registered one cycle after the strobe
		if (data_rd_i && data_addr_i == bmmc_pkg::CFG_ADDR) begin
			next_st.rdata = cfg_view;
		end else if (data_rd_i && data_addr_i == bmmc_pkg::USB_CONTROL_REG_ADDR) begin
			next_st.rdata = {st.bus_attach, 7'h00};
		end else if (data_rd_i) begin
			next_st.rdata = 8'h00;
		end
	end

	// state register; reset selects boot map and detached bus
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else if (clk_en_i) begin
			st <= next_st;
		end
	end

	// checks
	property p_boot_rom_low;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!map_eff && code_addr_i <= 16'h17FF) |-> rom_sel_o && code_off_o == code_addr_i;
	endproperty
	a_boot_rom_low: assert property (p_boot_rom_low) else $error("boot rom not at zero");

	property p_mirror;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(code_addr_i >= 16'h8000 && code_addr_i <= 16'h97FF) |->
			rom_sel_o && code_off_o == code_addr_i - 16'h8000;
	endproperty
	a_mirror: assert property (p_mirror) else $error("rom mirror decode wrong");

	property p_normal_code_ram;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(map_eff && code_addr_i <= 16'h1FFF) |-> ram_code_sel_o && !rom_sel_o;
	endproperty
	a_normal_code_ram: assert property (p_normal_code_ram) else $error("code ram missing");

	property p_data_ram;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(data_wr_i && data_addr_i <= 16'h1FFF) |-> (ram_data_we_o == !map_eff);
	endproperty
	a_data_ram: assert property (p_data_ram) else $error("data ram write gating wrong");

	property p_no_code_write;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		code_wr_i |-> !ram_code_we_o;
	endproperty
	a_no_code_write: assert property (p_no_code_write) else $error("code ram written");

	property p_io;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(data_addr_i >= 16'hFD80) |-> io_sel_o;
	endproperty
	a_io: assert property (p_io) else $error("io window not decoded");

	property p_map_sticky;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		st.map_release |=> st.map_release;
	endproperty
	a_map_sticky: assert property (p_map_sticky) else $error("map bit cleared");

	property p_map_set;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(clk_en_i && cfg_wr && data_wdata_i[0]) |=> st.map_release;
	endproperty
	a_map_set: assert property (p_map_set) else $error("map bit not set");

	property p_rev;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(clk_en_i && data_rd_i && data_addr_i == 16'hFF90) |=> reg_rdata_o[4:1] == REVISION;
	endproperty
	a_rev: assert property (p_rev) else $error("revision field wrong");

	property p_irq;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		external_interrupt_one_o == (st.irq_route ? (|port2_i) : port3_bit3_i);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt routing wrong");

	property p_variant;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		ROM_VARIANT |-> !map_normal_o;
	endproperty
	a_variant: assert property (p_variant) else $error("rom variant remapped");

	// the reset vector must land in the rom while the boot map stands
	property p_first_fetch;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!map_eff && code_addr_i == reset_vector_o) |-> rom_sel_o && code_off_o == 16'h0000;
	endproperty
	a_first_fetch: assert property (p_first_fetch) else $error("fetch not rom");

	// boot mode leaves a hole above the rom, so stray fetches select nothing
	property p_boot_gap;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!map_eff && code_addr_i > bmmc_pkg::ROM_HI && code_addr_i <= bmmc_pkg::RAM_HI) |->
			!rom_sel_o && !ram_code_sel_o;
	endproperty
	a_boot_gap: assert property (p_boot_gap) else $error("boot gap decoded");

	property p_low_rom_gone;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(map_eff && code_addr_i <= bmmc_pkg::ROM_HI) |-> !rom_sel_o;
	endproperty
	a_low_rom_gone: assert property (p_low_rom_gone) else $error("rom at zero");

	property p_ram_offset;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(map_eff && code_addr_i <= bmmc_pkg::RAM_HI) |-> code_off_o == code_addr_i;
	endproperty
	a_ram_offset: assert property (p_ram_offset) else $error("ram offset wrong");

	// data side of the shared ram follows the map bit for reads as well
	property p_data_read;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(data_rd_i && data_addr_i <= bmmc_pkg::RAM_HI) |-> (ram_data_re_o == !map_eff);
	endproperty
	a_data_read: assert property (p_data_read) else $error("ram read gating");

	// once the ram is code there is no data path left to write it through
	property p_ram_closed;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		map_eff |-> !ram_data_we_o && !ram_data_re_o;
	endproperty
	a_ram_closed: assert property (p_ram_closed) else $error("ram open as data");

	property p_io_no_ram;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(data_addr_i >= bmmc_pkg::IO_LO) |-> !ram_data_we_o && !ram_data_re_o;
	endproperty
	a_io_no_ram: assert property (p_io_no_ram) else $error("io hits ram");

	// the map bit may only rise through a written one
	property p_map_only_set;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!st.map_release && !(clk_en_i && cfg_wr && data_wdata_i[bmmc_pkg::MAP_BIT])) |=>
			!st.map_release;
	endproperty
	a_map_only_set: assert property (p_map_only_set) else $error("map self set");

	property p_clk_sel_wr;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(clk_en_i && cfg_wr) |=> clk_48m_sel_o == $past(data_wdata_i[bmmc_pkg::CLK_SEL_BIT]);
	endproperty
	a_clk_sel_wr: assert property (p_clk_sel_wr) else $error("clock sel write");

	property p_route_wr;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(clk_en_i && cfg_wr) |=> st.irq_route == $past(data_wdata_i[bmmc_pkg::IRQ_ROUTE_BIT]);
	endproperty
	a_route_wr: assert property (p_route_wr) else $error("route write");

	property p_attach_wr;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(clk_en_i && ctl_wr) |=> bus_attach_o == $past(data_wdata_i[bmmc_pkg::ATTACH_BIT]);
	endproperty
	a_attach_wr: assert property (p_attach_wr) else $error("attach write");

	// attach moves only on a write; the firmware alone orders it after the map switch
	property p_attach_hold;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		!(clk_en_i && ctl_wr) |=> $stable(bus_attach_o);
	endproperty
	a_attach_hold: assert property (p_attach_hold) else $error("attach moved");

	property p_ctl_read;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(clk_en_i && data_rd_i && data_addr_i == bmmc_pkg::USB_CONTROL_REG_ADDR) |=>
			reg_rdata_o == {$past(bus_attach_o), 7'h00};
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control read");

	property p_map_read;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(clk_en_i && data_rd_i && data_addr_i == bmmc_pkg::CFG_ADDR) |=>
			reg_rdata_o[bmmc_pkg::MAP_BIT] == $past(st.map_release);
	endproperty
	a_map_read: assert property (p_map_read) else $error("map readback");

	// read data stands until the next read; a low enable freezes every register
	property p_rdata_hold;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		!(clk_en_i && data_rd_i) |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	property p_freeze;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		!clk_en_i |=> $stable(st);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	c_switch: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!map_normal_o ##1 map_normal_o);
	c_attach: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		map_normal_o && !bus_attach_o ##1 bus_attach_o);
	c_blocked: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		map_normal_o && code_wr_i);
	c_data_load: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!map_normal_o && ram_data_we_o);
	c_freeze: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!clk_en_i && data_wr_i);
endmodule // bmmc_top

// [testbench/bmmc_fw_model.sv]
`timescale 1ns/1ps
// boot firmware of the core, seen as a data-space bus master
module bmmc_fw_model (
	// clock
	input wire logic sys_clk_i,
	// data-space bus
	output logic [15:0] data_addr_o,
	output logic data_rd_o,
	output logic data_wr_o,
	output logic [7:0] data_wdata_o,
	// read data
	input wire logic [7:0] reg_rdata_i
);
	// idle bus at time zero
	initial begin
		data_addr_o = 16'h0000;
		data_rd_o = 1'b0;
		data_wr_o = 1'b0;
		data_wdata_o = 8'h00;
	end
	// one-cycle write; released data is inverted so it never echoes
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1 data_addr_o = a;
		data_wdata_o = d;
		data_wr_o = 1'b1;
		@(posedge sys_clk_i);
		#1 data_wr_o = 1'b0;
		data_wdata_o = ~d;
	endtask
	// one-cycle read; data is registered at the taking edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		#1 data_addr_o = a;
		data_rd_o = 1'b1;
		@(posedge sys_clk_i);
		#1 data_rd_o = 1'b0;
		d = reg_rdata_i;
	endtask
	// load image, then switch map, only then attach
	task automatic boot(input bit sig_ok);
		if (sig_ok) wr(16'h0000, 8'h02);
		else wr(16'h0001, 8'h75);
		wr(bmmc_pkg::CFG_ADDR, 8'h01);
		wr(bmmc_pkg::USB_CONTROL_REG_ADDR, 8'h80);
	endtask
endmodule // bmmc_fw_model

// [testbench/bmmc_tb_top.sv]
`timescale 1ns/1ps
// bench: firmware model drives data space, bench drives code fetches
module bmmc_tb_top;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [15:0] ca = 16'h0000;
	logic cw = 1'b0;
	logic p33 = 1'b0;
	logic [7:0] p2 = 8'h00;
	logic [15:0] da, vec, coff;
	logic ce = 1'b1;
	logic drd, dwr, rwe, rre, io, rs, rcs, rcw, mapn, att, c48, irq, mapr;
	logic [7:0] wd, rdat, v;
	bmmc_pkg::bmmc_tgt_e dt, ct;
	int error_cnt = 0;
	int checks = 0;
	// 100 MHz clock
	always #5 sys_clk_i = ~sys_clk_i;
	bmmc_fw_model fw (.sys_clk_i(sys_clk_i), .data_addr_o(da), .data_rd_o(drd),
		.data_wr_o(dwr), .data_wdata_o(wd), .reg_rdata_i(rdat));
	bmmc_top uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(ce),
		.data_addr_i(da), .data_rd_i(drd), .data_wr_i(dwr), .data_wdata_i(wd),
		.reg_rdata_o(rdat), .data_tgt_o(dt), .ram_data_we_o(rwe), .ram_data_re_o(rre),
		.io_sel_o(io), .code_addr_i(ca), .code_wr_i(cw), .code_tgt_o(ct),
		.code_off_o(coff), .rom_sel_o(rs), .ram_code_sel_o(rcs), .ram_code_we_o(rcw),
		.reset_vector_o(vec), .map_normal_o(mapn), .bus_attach_o(att),
		.clk_48m_sel_o(c48), .port3_bit3_i(p33), .port2_i(p2),
		.external_interrupt_one_o(irq));
	// rom variant shares every input and must never leave the boot map
	bmmc_top #(.ROM_VARIANT(1'b1)) uut_rom (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(ce), .data_addr_i(da), .data_rd_i(drd), .data_wr_i(dwr), .data_wdata_i(wd),
		.reg_rdata_o(), .data_tgt_o(), .ram_data_we_o(), .ram_data_re_o(), .io_sel_o(),
		.code_addr_i(ca), .code_wr_i(cw), .code_tgt_o(), .code_off_o(), .rom_sel_o(),
		.ram_code_sel_o(), .ram_code_we_o(), .reset_vector_o(), .map_normal_o(mapr),
		.bus_attach_o(), .clk_48m_sel_o(), .port3_bit3_i(p33), .port2_i(p2),
		.external_interrupt_one_o());
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	// fetch address launched after an edge, decode checked once settled
	task automatic fetch(input logic [15:0] a, input bmmc_pkg::bmmc_tgt_e t,
		input logic [15:0] o);
		@(posedge sys_clk_i);
		#1 ca = a;
		#1 chk("code target", 16'(t), 16'(ct));
		chk("code offset", o, coff);
		chk("rom select", 16'(t == bmmc_pkg::BMMC_TGT_ROM), 16'(rs));
		chk("code ram select", 16'(t == bmmc_pkg::BMMC_TGT_RAM), 16'(rcs));
	endtask
	// data read with the RAM enable sampled inside the strobe cycle
	task automatic rchk(input logic [15:0] a, input logic e);
		fork
			fw.rd(a, v);
			begin
				@(posedge sys_clk_i);
				#2 chk("ram read", 16'(e), 16'(rre));
			end
		join
	endtask
	// data write with the RAM enable sampled inside the strobe cycle
	task automatic wchk(input logic [15:0] a, input logic e);
		fork
			fw.wr(a, 8'h5A);
			begin
				@(posedge sys_clk_i);
				#2 chk("ram write", 16'(e), 16'(rwe));
			end
		join
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// hang guard, far beyond the few dozen cycles the tests take
	initial begin
		#20000;
		error_cnt++;
		conclude;
	end
	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		chk("map", 16'h0, 16'(mapn));
		chk("attach", 16'h0, 16'(att));
		chk("vector", 16'h0000, vec);
		fetch(16'h0000, bmmc_pkg::BMMC_TGT_ROM, 16'h0000);
		fetch(16'h17FF, bmmc_pkg::BMMC_TGT_ROM, 16'h17FF);
		fetch(16'h1800, bmmc_pkg::BMMC_TGT_NONE, 16'h0000);
		fetch(16'h8000, bmmc_pkg::BMMC_TGT_ROM, 16'h0000);
		fetch(16'h97FF, bmmc_pkg::BMMC_TGT_ROM, 16'h17FF);
		wchk(16'h1FFF, 1'b1);
		chk("data target", 16'(bmmc_pkg::BMMC_TGT_RAM), 16'(dt));
		rchk(16'h0000, 1'b1);
		fw.wr(bmmc_pkg::CFG_ADDR, 8'h1E);
		fw.rd(bmmc_pkg::CFG_ADDR, v);
		chk("config", 16'h0002, 16'(v));
		@(posedge sys_clk_i);
		#1 p33 = 1'b1;
		#1 chk("irq", 16'h1, 16'(irq));
		fw.boot(1'b1);
		chk("map", 16'h1, 16'(mapn));
		chk("attach", 16'h1, 16'(att));
		chk("rom variant map", 16'h0, 16'(mapr));
		fw.rd(bmmc_pkg::USB_CONTROL_REG_ADDR, v);
		chk("control", 16'h0080, 16'(v));
		fetch(16'h0000, bmmc_pkg::BMMC_TGT_RAM, 16'h0000);
		fetch(16'h1FFF, bmmc_pkg::BMMC_TGT_RAM, 16'h1FFF);
		fetch(16'h8000, bmmc_pkg::BMMC_TGT_ROM, 16'h0000);
		fetch(16'h97FF, bmmc_pkg::BMMC_TGT_ROM, 16'h17FF);
		@(posedge sys_clk_i);
		#1 cw = 1'b1;
		#1 chk("code write", 16'h0, 16'(rcw));
		wchk(16'h0000, 1'b0);
		rchk(16'h0000, 1'b0);
		wchk(16'hFD80, 1'b0);
		chk("io select", 16'h1, 16'(io));
		chk("data target", 16'(bmmc_pkg::BMMC_TGT_IO), 16'(dt));
		fw.wr(bmmc_pkg::CFG_ADDR, 8'hC0);
		fw.rd(bmmc_pkg::CFG_ADDR, v);
		chk("config", 16'h00C3, 16'(v));
		chk("clock select", 16'h1, 16'(c48));
		@(posedge sys_clk_i);
		#1 p2 = 8'h10;
		p33 = 1'b0;
		#1 chk("irq", 16'h1, 16'(irq));
		@(posedge sys_clk_i);
		#1 sys_rst_i = 1'b1;
		@(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		ce = 1'b0;
		chk("map", 16'h0, 16'(mapn));
		chk("attach", 16'h0, 16'(att));
		chk("clock select", 16'h0, 16'(c48));
		// a set request while the enable is low must leave the map alone
		fw.wr(bmmc_pkg::CFG_ADDR, 8'h01);
		chk("frozen map", 16'h0, 16'(mapn));
		ce = 1'b1;
		fw.rd(bmmc_pkg::CFG_ADDR, v);
		chk("config", 16'h0002, 16'(v));
		fetch(16'h0000, bmmc_pkg::BMMC_TGT_ROM, 16'h0000);
		fw.boot(1'b0);
		chk("map", 16'h1, 16'(mapn));
		chk("attach", 16'h1, 16'(att));
		chk("rom variant map", 16'h0, 16'(mapr));
		conclude;
	end
endmodule // bmmc_tb_top
